/* File: hdl/mpc_check.sv */
// mpc_check: memory write parity generation, read parity check and
// installed memory address limit check.
// assumes access strobe and data come from logic on clk; the
// load clear and inhibit switch inputs come from outside and are
// synchronised; the limit straps are static.
//
// Contract
// - on write, generate odd parity over 16 data bits as bit 17.
// - parity bit is 1 for even ones, 0 for odd ones.
// - form parity on bits 1-8 and 9-16 separately, then combine.
// - on read, recompute parity and compare with stored bit 17.
// - error for bad stored bit or odd number of data bits flipped.
// - parity error suppressed throughout any memory write cycle.
// - load mode disables detection after clear until a memory cycle.
// - inhibit input asserted blocks all data parity error reports.
// - flag address error when address exceeds installed capacity.
// - add upper four address bits to limit digit; no carry is error.
// - with a 16K-word limit, 3FFF accepted and anything above errs.
// - stored word is 16 data bits plus generated bit 17.
// - on error pulse reset one clock, error logic is not cleared.
module mpc_check (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire mpc_pkg::mpc_access_t access,
  input  wire logic [15:0]          write_data,
  input  wire mpc_pkg::mpc_word_t   read_word,
  input  wire logic                 load_mode,
  input  wire logic                 load_clear_parity_n,
  input  wire logic                 inhibit_data_parity_n,
  input  wire logic [3:0]           limit_digit,
  input  wire logic                 limit_c0_en,
  output mpc_pkg::mpc_word_t        mem_word,
  output mpc_pkg::mpc_errors_t      errors,
  output logic                      address_error_n,
  output logic                      error_reset_pulse_n,
  output logic                      detect_enabled
);
  import mpc_pkg::*;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [1:0] clr_sync;
  logic [1:0] inh_sync;
  logic [1:0] next_clr_sync;
  logic [1:0] next_inh_sync;
  logic       clr_active;
  logic       inhibit_active;

  always_comb begin
    next_clr_sync = {clr_sync[0], load_clear_parity_n};
    next_inh_sync = {inh_sync[0], inhibit_data_parity_n};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      clr_sync <= 2'h3;
      inh_sync <= 2'h3;
    end else begin
      clr_sync <= next_clr_sync;
      inh_sync <= next_inh_sync;
    end
  end

  assign clr_active     = ~clr_sync[1];
  assign inhibit_active = ~inh_sync[1];

  // ****************************************************************
  // parity trees
  // ****************************************************************
  logic write_parity_low_half;
  logic write_parity_high_half;
  logic write_parity_bit;
  logic read_parity_low_half;
  logic read_parity_high_half;
  logic read_odd_bit;
  logic parity_mismatch;

  mpc_parity u_wr_parity (
    .data      (write_data),
    .low_half  (write_parity_low_half),
    .high_half (write_parity_high_half),
    .odd_bit   (write_parity_bit)
  );

  mpc_parity u_rd_parity (
    .data      (read_word.data),
    .low_half  (read_parity_low_half),
    .high_half (read_parity_high_half),
    .odd_bit   (read_odd_bit)
  );

  // any single stored bit flip or odd data flip changes the sum
  assign parity_mismatch = read_odd_bit ^ read_word.parity;

  // ****************************************************************
  // address limit adder
  // ****************************************************************
  logic limit_carry_out;

  // address bits enter the adder inverted, as on an active low bus, so
  // a carry out means the address is still inside the installed limit
  mpc_limit u_limit (
    .addr_hi         (~access.addr[ADDR_W-1:ADDR_HI_LSB]),
    .addr_c0         (~access.addr[ADDR_C0_BIT]),
    .limit_digit     (limit_digit),
    .limit_c0_en     (limit_c0_en),
    .limit_carry_out (limit_carry_out)
  );

  // ****************************************************************
  // load mode detection enable
  // ****************************************************************
  logic det_en;
  logic next_det_en;

  always_comb begin
    next_det_en = det_en;
    if (!load_mode) begin
      next_det_en = 1'b1;
    end else if (clr_active) begin
      next_det_en = 1'b0;
    end else if (access.valid) begin
      // the cycle itself still runs with the old enable
      next_det_en = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      det_en <= DET_EN_RST;
    end else begin
      det_en <= next_det_en;
    end
  end

  // ****************************************************************
  // error sampling and error reset pulse
  // ****************************************************************
  mpc_word_t      next_mem_word;
  mpc_errors_t    next_errors;
  mpc_err_state_t err_state;
  mpc_err_state_t next_err_state;
  logic           next_pulse_n;
  logic           par_err_now;
  logic           addr_err_now;
  logic           any_err;
  logic           allow_check;

  always_comb begin
    allow_check  = !access.write && det_en && !clr_active
                   && !inhibit_active;
    par_err_now  = access.valid && parity_mismatch
                   && allow_check;
    // no carry out means the address runs past the limit
    addr_err_now = access.valid && !limit_carry_out;
    any_err      = par_err_now || addr_err_now;
    next_errors.parity_error_flag = par_err_now;
    next_errors.address_error     = addr_err_now;
    next_mem_word.data   = write_data;
    next_mem_word.parity = write_parity_bit;
  end

  always_comb begin
    next_err_state = err_state;
    next_pulse_n   = 1'b1;
    case (err_state)
      MPC_IDLE: begin
        if (any_err) begin
          next_err_state = MPC_PULSE;
          next_pulse_n   = 1'b0;
        end
      end
      MPC_PULSE: begin
        // one clock low only; error flags are left alone
        next_err_state = any_err ? MPC_HOLD : MPC_IDLE;
      end
      MPC_HOLD: begin
        if (!any_err) begin
          next_err_state = MPC_IDLE;
        end
      end
      default: begin
        next_err_state = MPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_word            <= '0;
      errors              <= '0;
      address_error_n     <= 1'b1;
      error_reset_pulse_n <= 1'b1;
      detect_enabled      <= DET_EN_RST;
      err_state           <= MPC_IDLE;
    end else begin
      mem_word            <= next_mem_word;
      errors              <= next_errors;
      address_error_n     <= ~next_errors.address_error;
      error_reset_pulse_n <= next_pulse_n;
      detect_enabled      <= next_det_en;
      err_state           <= next_err_state;
    end
  end

endmodule // mpc_check

/* File: hdl/mpc_pkg.sv */
// mpc_pkg: shared types and constants for the memory parity and
// address limit checker.
// assumes a single 100 MHz system clock and synchronous reset.
package mpc_pkg;

  // ****************************************************************
  // widths and field positions
  // ****************************************************************
  localparam int DATA_W       = 16;
  localparam int HALF_W       = 8;
  localparam int WORD_W       = 17;
  localparam int ADDR_W       = 16;
  localparam int LIMIT_W      = 4;
  localparam int ADDR_HI_LSB  = 12;
  localparam int ADDR_C0_BIT  = 11;

  // ****************************************************************
  // reset values and counts
  // ****************************************************************
  localparam logic       FLAG_RST      = 1'h0;
  localparam logic       DET_EN_RST    = 1'h1;
  localparam int         CLK_MHZ       = 100;
  localparam int         ERR_PULSE_NS  = 10;
  localparam int         ERR_PULSE_CYC =
    (ERR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] ERR_CNT_RST   = 2'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              parity;
  } mpc_word_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } mpc_access_t;

  typedef struct packed {
    logic parity_error_flag;
    logic address_error;
  } mpc_errors_t;

  typedef enum logic [1:0] {
    MPC_IDLE  = 2'b00,
    MPC_PULSE = 2'b01,
    MPC_HOLD  = 2'b11
  } mpc_err_state_t;

endpackage : mpc_pkg

/* File: hdl/mpc_parity.sv */
// mpc_parity: combinational odd parity over 16 bits as two halves.
// assumes the caller registers the result where timing matters.
module mpc_parity (
  input  wire logic [15:0] data,
  output logic             low_half,
  output logic             high_half,
  output logic             odd_bit
);
  import mpc_pkg::*;

  always_comb begin
    low_half  = ^data[HALF_W-1:0];
    high_half = ^data[DATA_W-1:HALF_W];
    // even count of ones gives 1 so the stored word is odd
    odd_bit   = ~(low_half ^ high_half);
  end

endmodule // mpc_parity

/* File: hdl/mpc_limit.sv */
// mpc_limit: four bit adder compare of address against wired limit.
// assumes limit inputs are static straps, no synchroniser needed.
module mpc_limit (
  input  wire logic [3:0] addr_hi,
  input  wire logic       addr_c0,
  input  wire logic [3:0] limit_digit,
  input  wire logic       limit_c0_en,
  output logic            limit_carry_out
);
  import mpc_pkg::*;

  logic       limit_carry_in;
  logic [4:0] sum;

  always_comb begin
    // carry in from address bit and the wired limit together
    limit_carry_in  = addr_c0 & limit_c0_en;
    sum             = {1'b0, addr_hi} + {1'b0, limit_digit}
                      + {4'h0, limit_carry_in};
    limit_carry_out = sum[LIMIT_W];
  end

endmodule // mpc_limit

/* File: tb/mpc_check_props.sv */
// mpc_check_props: port checks for mpc_check.
// assumes one clock domain, srst synchronous active high.
module mpc_check_props
  import mpc_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire mpc_access_t access,
  input wire logic [15:0] write_data,
  input wire mpc_word_t   read_word,
  input wire logic        load_mode,
  input wire logic        load_clear_parity_n,
  input wire logic        inhibit_data_parity_n,
  input wire logic [3:0]  limit_digit,
  input wire logic        limit_c0_en,
  input wire mpc_word_t   mem_word,
  input wire mpc_errors_t errors,
  input wire logic        address_error_n,
  input wire logic        error_reset_pulse_n,
  input wire logic        detect_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // assertions
  // ****************************************
  logic rd_bad;
  logic above;
  logic any_err;
  assign rd_bad = access.valid && !access.write && !(^read_word)
    && detect_enabled;
  assign above = access.addr > 16'h3FFF;
  assign any_err = |errors;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  word_gen_a: assert property (1'b1 |=>
    mem_word == {$past(write_data), ~^$past(write_data)})
    else $error("stored word wrong");
  write_quiet_a: assert property (access.valid && access.write
    |=> !errors.parity_error_flag) else $error("error on write");
  inhibit_a: assert property (!inhibit_data_parity_n [*3]
    |=> !errors.parity_error_flag) else $error("inhibit ignored");
  par_detect_a: assert property ((inhibit_data_parity_n &&
    load_clear_parity_n) [*3] ##0 rd_bad |=> errors.parity_error_flag)
    else $error("parity error missed");
  par_cause_a: assert property (errors.parity_error_flag
    |-> $past(rd_bad)) else $error("parity error without cause");
  limit_16k_a: assert property (access.valid && limit_digit == 4'h4
    && !limit_c0_en |=> errors.address_error == $past(above))
    else $error("address limit wrong");
  addr_idle_a: assert property (!access.valid |=>
    errors == 2'h0 && address_error_n) else $error("flag without access");
  err_pulse_a: assert property ($rose(any_err) |->
    !error_reset_pulse_n ##1 error_reset_pulse_n)
    else $error("error pulse wrong");
  det_norm_a: assert property (!load_mode |=> detect_enabled)
    else $error("detection off outside load");
  det_clear_a: assert property ((load_mode && !load_clear_parity_n
    && !access.valid) [*3] |=> !detect_enabled)
    else $error("load clear ignored");
endmodule // mpc_check_props

/* File: tb/mpc_mem_model.sv */
// mpc_mem_model: behavioural word store beside mpc_check.
// assumes the generated bit arrives one cycle after the write.
module mpc_mem_model
  import mpc_pkg::*;
(
  input wire logic        clk,
  input wire mpc_access_t access,
  input wire mpc_word_t   mem_word,
  input wire logic [16:0] flip,
  output mpc_word_t       read_word
);
  timeunit 1ns;
  timeprecision 1ps;
  mpc_word_t  mem [16];
  logic       pend = 1'b0;
  logic [3:0] paddr = 4'h0;
  // blank words carry good parity so reads of unwritten words stay quiet
  initial foreach (mem[i]) mem[i] = '{16'h0, 1'b1};
  always @(posedge clk) begin
    if (pend) mem[paddr] <= mem_word;
    pend  <= access.valid && access.write;
    paddr <= access.addr[3:0];
  end
  // unselected store shows the inverse, never a stale copy
  assign read_word = (access.valid && !access.write)
    ? mem[access.addr[3:0]] ^ flip : ~mem[access.addr[3:0]];
endmodule // mpc_mem_model

/* File: tb/tb.sv */
// tb: self-checking bench for mpc_check.
// assumes mpc_pkg, the design and tb/mpc_mem_model are compiled first.
module tb;
  import mpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, srst = 1'b1, load_mode = 1'b0;
  logic        load_clear_parity_n = 1'b1, inhibit_data_parity_n = 1'b1;
  logic        limit_c0_en = 1'b0, address_error_n;
  logic        error_reset_pulse_n, detect_enabled;
  logic [3:0]  limit_digit = 4'h4;
  logic [15:0] write_data = 16'h0;
  logic [16:0] flip = 17'h0;
  mpc_access_t access = '0;
  mpc_word_t   mem_word, read_word;
  mpc_errors_t errors;
  int          miscompares = 0, n_tests = 0, cyc = 0;
  logic [15:0] pat [5] = '{16'h0000, 16'hFFFF, 16'h0001, 16'h8000, 16'hA5A4};
  logic [16:0] fl [5] = '{17'h1, 17'h2, 17'h18000, 17'h10100, 17'h1C000};
  logic [15:0] ad [6] = '{16'h3FFF, 16'h4000, 16'h0, 16'hFFFF, 16'h2000,
    16'h7FFF};
  always #5 clk = ~clk;
  mpc_check u_dut (
    .clk                   (clk),
    .srst                  (srst),
    .access                (access),
    .write_data            (write_data),
    .read_word             (read_word),
    .load_mode             (load_mode),
    .load_clear_parity_n   (load_clear_parity_n),
    .inhibit_data_parity_n (inhibit_data_parity_n),
    .limit_digit           (limit_digit),
    .limit_c0_en           (limit_c0_en),
    .mem_word              (mem_word),
    .errors                (errors),
    .address_error_n       (address_error_n),
    .error_reset_pulse_n   (error_reset_pulse_n),
    .detect_enabled        (detect_enabled)
  );
  mpc_mem_model u_mem (.clk(clk), .access(access), .mem_word(mem_word),
    .flip(flip), .read_word(read_word));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // idle cycle after each access keeps the store model out of a race
  task automatic acc(input logic wr, input logic [15:0] a, d,
                     input logic [1:0] exp);
    access <= '{1'b1, wr, a};
    write_data <= d;
    idle(1);
    access.valid <= 1'b0;
    chk(errors === exp, "error flags");
    chk(address_error_n === !exp[0], "address flag");
    chk(error_reset_pulse_n === !(|exp), "error pulse");
    if (wr) chk(mem_word === {d, ~^d}, "stored word");
    idle(1);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      miscompares++;
      conclude();
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    idle(4);
    srst = 1'b0;
    chk(errors === 2'h0 && detect_enabled === 1'b1, "reset state");
    foreach (pat[i]) begin
      acc(1'b1, 16'(i), pat[i], 2'h0);
      acc(1'b0, 16'(i), 16'h0, 2'h0);
    end
    foreach (fl[i]) begin
      flip = fl[i];
      acc(1'b0, 16'h2, 16'h0, {^fl[i], 1'b0});
    end
    flip = 17'h1;
    acc(1'b1, 16'h5, 16'h1234, 2'h0);
    inhibit_data_parity_n = 1'b0;
    idle(3);
    acc(1'b0, 16'h2, 16'h0, 2'h0);
    inhibit_data_parity_n = 1'b1;
    load_mode = 1'b1;
    load_clear_parity_n = 1'b0;
    idle(3);
    load_clear_parity_n = 1'b1;
    idle(3);
    chk(detect_enabled === 1'b0, "detection held off");
    acc(1'b0, 16'h2, 16'h0, 2'h0);
    acc(1'b0, 16'h2, 16'h0, 2'h2);
    load_mode = 1'b0;
    flip = 17'h0;
    foreach (ad[i]) acc(1'b0, ad[i], 16'h0, {1'b0, ad[i] > 16'h3FFF});
    // straps change only between accesses, as at a reinstall
    limit_c0_en = 1'b1;
    acc(1'b0, 16'h47FF, 16'h0, 2'h0);
    acc(1'b0, 16'h4800, 16'h0, 2'h1);
    conclude();
  end
endmodule // tb
bind mpc_check mpc_check_props u_props (
  .clk                   (clk),
  .srst                  (srst),
  .access                (access),
  .write_data            (write_data),
  .read_word             (read_word),
  .load_mode             (load_mode),
  .load_clear_parity_n   (load_clear_parity_n),
  .inhibit_data_parity_n (inhibit_data_parity_n),
  .limit_digit           (limit_digit),
  .limit_c0_en           (limit_c0_en),
  .mem_word              (mem_word),
  .errors                (errors),
  .address_error_n       (address_error_n),
  .error_reset_pulse_n   (error_reset_pulse_n),
  .detect_enabled        (detect_enabled)
);
